//--- serial_link_pkg.sv
// Constants, field layout and mode decoding for the serial link control registers
package serial_link_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam int          CFG_ADDR_W             = 12;
  localparam logic [11:0] ADDR_LINK_ENABLE       = 12'h200;
  localparam logic [11:0] ADDR_LINK_MODE         = 12'h201;
  localparam logic [11:0] ADDR_MULTIFRAME_LENGTH = 12'h202;
  localparam logic [11:0] ADDR_SW_SYNC           = 12'h203;
  localparam logic [11:0] ADDR_LINK_CONTROL      = 12'h204;

  localparam logic [7:0]  RST_LINK_ENABLE        = 8'h01;
  localparam logic [7:0]  RST_LINK_MODE          = 8'h02;
  localparam logic [7:0]  RST_MULTIFRAME_LENGTH  = 8'h1F;
  localparam logic [7:0]  RST_SW_SYNC            = 8'h01;
  localparam logic [7:0]  RST_LINK_CONTROL       = 8'h03;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int BIT_LINK_ENABLE   = 0;
  localparam int BIT_SYNC_N        = 0;
  localparam int BIT_SCRAMBLER     = 0;
  localparam int BIT_SAMPLE_FORMAT = 1;
  localparam int SYNC_SEL_LSB      = 2;
  localparam int BIT_UPPER_LANES   = 4;

  localparam logic [1:0] SYNC_SRC_DEDICATED = 2'h0;
  localparam logic [1:0] SYNC_SRC_TIMESTAMP = 2'h1;
  localparam logic [1:0] SYNC_SRC_NONE      = 2'h2;

  // ----------------------------------------------------------------
  // Mode decoding
  // ----------------------------------------------------------------
  localparam int         K_64B_SCALE  = 256;
  localparam int         LANES_PER_LINK = 8;
  localparam logic [7:0] MODE_64B_FIRST = 8'h10;

  function automatic logic mode_is_64b(input logic [7:0] mode);
    return mode >= MODE_64B_FIRST;
  endfunction : mode_is_64b

  // Octets per frame as a power of two taken from the low mode bits
  function automatic logic [3:0] mode_f(input logic [7:0] mode);
    return 4'h1 << mode[1:0];
  endfunction : mode_f

  // Multiblocks per extended multiblock
  function automatic logic [3:0] mode_e(input logic [7:0] mode);
    return {3'h0, 1'b1} << mode[3:2];
  endfunction : mode_e

  // Modes with bit 2 set use more than eight lanes per device
  function automatic logic mode_wide(input logic [7:0] mode);
    return mode[2];
  endfunction : mode_wide

endpackage : serial_link_pkg

//--- serial_link_if.sv
// Link between the converter's transmit end and the receiver logic
`timescale 1ns/100ps
`default_nettype none
interface serial_link_if;
  import serial_link_pkg::*;

  logic [LANES_PER_LINK-1:0] lane_on_a;
  logic [LANES_PER_LINK-1:0] lane_on_b;
  logic                      link_active;
  logic                      scrambling;
  logic                      twos_complement;
  logic [8:0]                k_frames;
  logic                      multiframe_start;
  logic                      sync_pending;
  logic                      dedicated_sync_n;
  logic                      timestamp_level;

  modport transmitter (
    output lane_on_a, lane_on_b, link_active, scrambling, twos_complement,
    output k_frames, multiframe_start, sync_pending,
    input  dedicated_sync_n, timestamp_level
  );

  modport receiver (
    input  lane_on_a, lane_on_b, link_active, scrambling, twos_complement,
    input  k_frames, multiframe_start, sync_pending,
    output dedicated_sync_n, timestamp_level
  );
endinterface : serial_link_if
`default_nettype wire

//--- serial_link_control_regs.sv
// Transmit end: configuration registers and the link settings they steer
`timescale 1ns/100ps
`default_nettype none
module serial_link_control_regs
  import serial_link_pkg::*;
(
  // Clock and reset
  input  wire logic                  clk_sys_i,
  input  wire logic                  rst_n_i,
  // Configuration port
  input  wire logic [CFG_ADDR_W-1:0] cfg_addr_i,
  input  wire logic [7:0]            cfg_wdata_i,
  input  wire logic                  cfg_wr_i,
  input  wire logic                  cfg_rd_i,
  output logic      [7:0]            cfg_rdata_o,
  output logic                       cfg_rvalid_o,
  // Side controls
  input  wire logic                  timestamp_receiver_enable_i,
  // Link
  serial_link_if.transmitter         link
);

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [7:0] link_subsystem_enable;
  logic [7:0] link_mode_select;
  logic [7:0] frames_per_multiframe_minus_one;
  logic [7:0] software_sync_request_n;
  logic [7:0] link_control_reg;

  logic wr_enable;
  logic wr_mode;
  logic wr_length;
  logic wr_sync;
  logic wr_control;

  assign wr_enable  = cfg_wr_i && cfg_addr_i == ADDR_LINK_ENABLE;
  assign wr_mode    = cfg_wr_i && cfg_addr_i == ADDR_LINK_MODE;
  assign wr_length  = cfg_wr_i && cfg_addr_i == ADDR_MULTIFRAME_LENGTH;
  assign wr_sync    = cfg_wr_i && cfg_addr_i == ADDR_SW_SYNC;
  assign wr_control = cfg_wr_i && cfg_addr_i == ADDR_LINK_CONTROL;

  // Reserved bits are stored whole and read back, but no link logic below looks at them
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      link_subsystem_enable <= RST_LINK_ENABLE;
    end else if (wr_enable) begin
      link_subsystem_enable <= cfg_wdata_i;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      link_mode_select <= RST_LINK_MODE;
    end else if (wr_mode) begin
      link_mode_select <= cfg_wdata_i;
    end
  end

  // Writes are taken even while enabled; keeping them legal is software's job
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      frames_per_multiframe_minus_one <= RST_MULTIFRAME_LENGTH;
    end else if (wr_length) begin
      frames_per_multiframe_minus_one <= cfg_wdata_i;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      software_sync_request_n <= RST_SW_SYNC;
    end else if (wr_sync) begin
      software_sync_request_n <= cfg_wdata_i;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      link_control_reg <= RST_LINK_CONTROL;
    end else if (wr_control) begin
      link_control_reg <= cfg_wdata_i;
    end
  end

  // ----------------------------------------------------------------
  // Read port
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      cfg_rdata_o  <= 8'h00;
      cfg_rvalid_o <= 1'b0;
    end else begin
      cfg_rvalid_o <= cfg_rd_i;
      if (cfg_rd_i) begin
        unique case (cfg_addr_i)
          ADDR_LINK_ENABLE:       cfg_rdata_o <= link_subsystem_enable;
          ADDR_LINK_MODE:         cfg_rdata_o <= link_mode_select;
          ADDR_MULTIFRAME_LENGTH: cfg_rdata_o <= frames_per_multiframe_minus_one;
          ADDR_SW_SYNC:           cfg_rdata_o <= software_sync_request_n;
          ADDR_LINK_CONTROL:      cfg_rdata_o <= link_control_reg;
          default:                cfg_rdata_o <= 8'h00;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Derived settings
  // ----------------------------------------------------------------
  logic       enabled;
  logic       is_64b;
  logic       upper_lane_select;
  logic [1:0] sync_source;
  logic [8:0] next_k;
  logic       pin_request;
  logic       sw_request;

  assign enabled           = link_subsystem_enable[BIT_LINK_ENABLE];
  assign is_64b            = mode_is_64b(link_mode_select);
  assign upper_lane_select = link_control_reg[BIT_UPPER_LANES];
  assign sync_source       = link_control_reg[SYNC_SEL_LSB +: 2];

  // 64b/66b takes K from the mode; 8b/10b adds one to the stored byte
  always_comb begin
    if (is_64b) begin
      next_k = 9'(K_64B_SCALE * int'(mode_e(link_mode_select))
                 / int'(mode_f(link_mode_select)));
    end else begin
      next_k = {1'b0, frames_per_multiframe_minus_one} + 9'h001;
    end
  end

  // Code 3 is treated like code 2 so an unused code cannot hold a pin request
  always_comb begin
    unique case (sync_source)
      SYNC_SRC_DEDICATED: pin_request = !link.dedicated_sync_n;
      SYNC_SRC_TIMESTAMP: pin_request = !link.timestamp_level
                                        && timestamp_receiver_enable_i;
      default:            pin_request = 1'b0;
    endcase
  end

  assign sw_request = !software_sync_request_n[BIT_SYNC_N];

  // ----------------------------------------------------------------
  // Link outputs
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i || !enabled) begin
      link.sync_pending <= 1'b0;
    end else begin
      link.sync_pending <= sw_request || pin_request;
    end
  end

  // Wide modes with the upper bit set are undefined; the mapping still applies
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i || !enabled) begin
      link.lane_on_a <= '0;
      link.lane_on_b <= '0;
    end else if (upper_lane_select) begin
      link.lane_on_a <= 8'hF0;
      link.lane_on_b <= 8'hF0;
    end else begin
      link.lane_on_a <= 8'h0F;
      link.lane_on_b <= 8'h0F;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      link.link_active     <= 1'b0;
      link.scrambling      <= 1'b0;
      link.twos_complement <= 1'b0;
      link.k_frames        <= 9'h000;
    end else begin
      link.link_active     <= enabled;
      link.scrambling      <= is_64b || link_control_reg[BIT_SCRAMBLER];
      link.twos_complement <= link_control_reg[BIT_SAMPLE_FORMAT];
      link.k_frames        <= next_k;
    end
  end

  // ----------------------------------------------------------------
  // Multiframe counter, one frame per clock
  // ----------------------------------------------------------------
  logic [8:0] frame_count;

  // Held at zero while disabled so the first boundary follows enabling
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i || !enabled) begin
      frame_count <= 9'h000;
    end else if (frame_count + 9'h001 >= next_k) begin
      frame_count <= 9'h000;
    end else begin
      frame_count <= frame_count + 9'h001;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i || !enabled) begin
      link.multiframe_start <= 1'b0;
    end else begin
      link.multiframe_start <= frame_count == 9'h000;
    end
  end

endmodule : serial_link_control_regs
`default_nettype wire

//--- serial_link_receiver_end.sv
// Receiver end: drives sync pins and captures the transmitter's settings
`timescale 1ns/100ps
`default_nettype none
module serial_link_receiver_end
  import serial_link_pkg::*;
(
  // Clock and reset
  input  wire logic                      clk_sys_i,
  input  wire logic                      rst_n_i,
  // User side
  input  wire logic                      resync_request_i,
  input  wire logic                      timestamp_i,
  output logic                           link_up_o,
  output logic                           scrambled_o,
  output logic                           twos_complement_o,
  output logic      [8:0]                k_frames_o,
  output logic                           multiframe_o,
  output logic                           sync_pending_o,
  output logic      [LANES_PER_LINK-1:0] lanes_a_o,
  output logic      [LANES_PER_LINK-1:0] lanes_b_o,
  // Link
  serial_link_if.receiver                link
);

  // ----------------------------------------------------------------
  // Pins toward the transmitter
  // ----------------------------------------------------------------
  // Sync is active low; idle high so a reset receiver never stalls the link
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      link.dedicated_sync_n <= 1'b1;
      link.timestamp_level  <= 1'b1;
    end else begin
      link.dedicated_sync_n <= !resync_request_i;
      link.timestamp_level  <= timestamp_i;
    end
  end

  // ----------------------------------------------------------------
  // Captured settings
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      link_up_o         <= 1'b0;
      scrambled_o       <= 1'b0;
      twos_complement_o <= 1'b0;
      k_frames_o        <= 9'h000;
      multiframe_o      <= 1'b0;
      sync_pending_o    <= 1'b0;
      lanes_a_o         <= '0;
      lanes_b_o         <= '0;
    end else begin
      link_up_o         <= link.link_active && |link.lane_on_a;
      scrambled_o       <= link.scrambling;
      twos_complement_o <= link.twos_complement;
      k_frames_o        <= link.k_frames;
      multiframe_o      <= link.multiframe_start;
      sync_pending_o    <= link.sync_pending;
      lanes_a_o         <= link.lane_on_a;
      lanes_b_o         <= link.lane_on_b;
    end
  end

endmodule : serial_link_receiver_end
`default_nettype wire

//--- serial_link_checker.sv
// Concurrent checks on the link between transmit and receiver ends
`timescale 1ns/100ps
`default_nettype none
module serial_link_checker
  import serial_link_pkg::*;
(
  // Clock and reset
  input wire logic                      clk_sys_i,
  input wire logic                      rst_n_i,
  // Link
  input wire logic [LANES_PER_LINK-1:0] lane_on_a,
  input wire logic [LANES_PER_LINK-1:0] lane_on_b,
  input wire logic                      link_active,
  input wire logic                      scrambling,
  input wire logic                      twos_complement,
  input wire logic [8:0]                k_frames,
  input wire logic                      multiframe_start,
  input wire logic                      sync_pending,
  input wire logic                      dedicated_sync_n,
  input wire logic                      timestamp_level
);
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n_i);
  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  AST_LANE_HALF: assert property (
    link_active |-> lane_on_a == 8'h0F || lane_on_a == 8'hF0) else $error("lane set not a half");
  AST_LANE_PAIR: assert property (
    lane_on_a == lane_on_b) else $error("link lane sets differ");
  AST_DISABLED_QUIET: assert property (
    !link_active |-> lane_on_a == 8'h00 && !multiframe_start && !sync_pending)
    else $error("disabled link not quiet");
  AST_RESET_STATE: assert property (
    $rose(rst_n_i) |=> link_active && k_frames == 9'h020 && lane_on_a == 8'h0F
    && scrambling && twos_complement) else $error("state after reset wrong");
  AST_MF_AFTER_ENABLE: assert property (
    $rose(link_active) |-> multiframe_start) else $error("no multiframe after enable");
  AST_MF_PERIOD: assert property (
    multiframe_start && k_frames == 9'h004 |=> !multiframe_start [*3] ##1
    (multiframe_start || !link_active)) else $error("multiframe period wrong");
  AST_MF_SINGLE: assert property (
    multiframe_start && k_frames > 9'h001 |=> !multiframe_start)
    else $error("multiframe pulse too long");
  AST_K_NONZERO: assert property (
    link_active |-> k_frames != 9'h000) else $error("zero frames per multiframe");
  // ----------------------------------------------------------------
  // Coverage
  // ----------------------------------------------------------------
  cover property (multiframe_start);
  cover property (lane_on_a == 8'hF0);
  cover property (!dedicated_sync_n ##2 sync_pending);
  cover property (!timestamp_level && sync_pending);
endmodule : serial_link_checker
`default_nettype wire

//--- test_serial_link_control_regs.sv
// Self-checking bench joining transmit and receiver ends
`timescale 1ns/100ps
`default_nettype none
module test_serial_link_control_regs;
  import serial_link_pkg::*;
  logic        clk_sys_i, rst_n_i, cfg_wr_i, cfg_rd_i, cfg_rvalid;
  logic        ts_en, resync, tstamp, link_up, scrambled, twos, mf_rx, sync_rx;
  logic [11:0] cfg_addr;
  logic [7:0]  cfg_wdata, cfg_rdata, lanes_a, lanes_b;
  logic [8:0]  k_rx;
  int          miscompares, tests_run, cycles;
  logic [7:0]  rst_tab [6] = '{8'h01, 8'h02, 8'h1F, 8'h01, 8'h03, 8'h00};

  serial_link_if link_if ();
  serial_link_control_regs u_serial_link_control_regs (.clk_sys_i(clk_sys_i),
    .rst_n_i(rst_n_i), .cfg_addr_i(cfg_addr), .cfg_wdata_i(cfg_wdata), .cfg_wr_i(cfg_wr_i),
    .cfg_rd_i(cfg_rd_i), .cfg_rdata_o(cfg_rdata), .cfg_rvalid_o(cfg_rvalid),
    .timestamp_receiver_enable_i(ts_en), .link(link_if.transmitter));
  serial_link_receiver_end u_serial_link_receiver_end (.clk_sys_i(clk_sys_i),
    .rst_n_i(rst_n_i), .resync_request_i(resync), .timestamp_i(tstamp), .link_up_o(link_up),
    .scrambled_o(scrambled), .twos_complement_o(twos), .k_frames_o(k_rx), .multiframe_o(mf_rx),
    .sync_pending_o(sync_rx), .lanes_a_o(lanes_a), .lanes_b_o(lanes_b),
    .link(link_if.receiver));
  serial_link_checker u_serial_link_checker (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i),
    .lane_on_a(link_if.lane_on_a), .lane_on_b(link_if.lane_on_b),
    .link_active(link_if.link_active), .scrambling(link_if.scrambling),
    .twos_complement(link_if.twos_complement), .k_frames(link_if.k_frames),
    .multiframe_start(link_if.multiframe_start), .sync_pending(link_if.sync_pending),
    .dedicated_sync_n(link_if.dedicated_sync_n), .timestamp_level(link_if.timestamp_level));

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic stop_test;
    $display("Comparisons %0d miscompares %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : stop_test
  task automatic chk(input string n, input logic [8:0] e, input logic [8:0] g);
    tests_run++;
    if (g !== e) begin
      miscompares++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic settle;
    repeat (4) @(posedge clk_sys_i);
    #1;
  endtask : settle
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(posedge clk_sys_i);
    cfg_addr  <= a;
    cfg_wdata <= d;
    cfg_wr_i  <= 1'b1;
    @(posedge clk_sys_i);
    cfg_wr_i  <= 1'b0;
  endtask : wr
  task automatic rd(input logic [11:0] a, input logic [7:0] e);
    @(posedge clk_sys_i);
    cfg_addr <= a;
    cfg_rd_i <= 1'b1;
    @(posedge clk_sys_i);
    cfg_rd_i <= 1'b0;
    #1;
    chk("rvalid", 9'h001, {8'h00, cfg_rvalid});
    chk("rdata", {1'b0, e}, {1'b0, cfg_rdata});
  endtask : rd
  // Pins are set after the control write, then the combined request is seen
  task automatic sy(input logic [7:0] c, input logic r, t, en, x);
    wr(12'h204, c);
    resync <= r;
    tstamp <= t;
    ts_en  <= en;
    settle;
    chk("sync", {8'h00, x}, {8'h00, sync_rx});
  endtask : sy
  // Bounded so a dead counter cannot hang the run
  // Sampled just after each edge so one pulse is never counted twice
  task automatic mf_gap(input logic [8:0] e);
    int n;
    n = 0;
    while (!mf_rx && n < 600) begin
      @(posedge clk_sys_i);
      #1;
      n++;
    end
    @(posedge clk_sys_i);
    #1;
    n = 1;
    while (!mf_rx && n < 600) begin
      @(posedge clk_sys_i);
      #1;
      n++;
    end
    chk("mf_gap", e, 9'(n));
  endtask : mf_gap

  // ----------------------------------------------------------------
  // Sequence
  // ----------------------------------------------------------------
  initial begin
    clk_sys_i = 1'b0;
    forever #5 clk_sys_i = ~clk_sys_i;
  end
  always @(posedge clk_sys_i) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      miscompares++;
      stop_test;
    end
  end
  initial begin
    {rst_n_i, cfg_wr_i, cfg_rd_i, ts_en, resync, cfg_addr, cfg_wdata} = '0;
    {miscompares, tests_run} = '0;
    tstamp = 1'b1;
    repeat (20) @(posedge clk_sys_i);
    rst_n_i <= 1'b1;
    settle;
    for (int i = 0; i < 6; i++) rd(12'h200 + 12'(i), rst_tab[i]);
    chk("k", 9'h020, k_rx);
    chk("lanes_a", 9'h00F, {1'b0, lanes_a});
    chk("lanes_b", 9'h00F, {1'b0, lanes_b});
    chk("scr_fmt", 9'h003, {7'h00, scrambled, twos});
    sy(8'h03, 1'b1, 1'b1, 1'b0, 1'b1);
    sy(8'h03, 1'b0, 1'b1, 1'b0, 1'b0);
    sy(8'h07, 1'b0, 1'b0, 1'b1, 1'b1);
    sy(8'h07, 1'b1, 1'b1, 1'b1, 1'b0);
    sy(8'h0B, 1'b1, 1'b0, 1'b1, 1'b0);
    wr(12'h203, 8'h00);
    settle;
    chk("sync", 9'h001, {8'h00, sync_rx});
    sy(8'h03, 1'b0, 1'b1, 1'b0, 1'b1);
    wr(12'h203, 8'hFF);
    sy(8'h11, 1'b0, 1'b1, 1'b0, 1'b0);
    rd(12'h203, 8'hFF);
    chk("lanes_a", 9'h0F0, {1'b0, lanes_a});
    chk("lanes_b", 9'h0F0, {1'b0, lanes_b});
    chk("scr_fmt", 9'h002, {7'h00, scrambled, twos});
    wr(12'h204, 8'hE3);
    settle;
    chk("lanes_a", 9'h00F, {1'b0, lanes_a});
    rd(12'h204, 8'hE3);
    wr(12'h200, 8'h00);
    wr(12'h203, 8'h00);
    settle;
    chk("link", 9'h000, {link_up, lanes_a});
    chk("sync", 9'h000, {8'h00, sync_rx});
    wr(12'h203, 8'h01);
    wr(12'h202, 8'h03);
    wr(12'h204, 8'h00);
    wr(12'h200, 8'h01);
    settle;
    rd(12'h202, 8'h03);
    chk("k", 9'h004, k_rx);
    chk("scr_fmt", 9'h000, {7'h00, scrambled, twos});
    mf_gap(9'h004);
    wr(12'h200, 8'h00);
    wr(12'h202, 8'hFF);
    wr(12'h200, 8'h01);
    settle;
    chk("k", 9'h100, k_rx);
    wr(12'h200, 8'h00);
    wr(12'h201, 8'h11);
    wr(12'h200, 8'h01);
    settle;
    chk("k", 9'h080, k_rx);
    chk("scr_fmt", 9'h002, {7'h00, scrambled, twos});
    mf_gap(9'h080);
    @(posedge clk_sys_i);
    rst_n_i <= 1'b0;
    repeat (2) @(posedge clk_sys_i);
    rst_n_i <= 1'b1;
    settle;
    rd(12'h202, 8'h1F);
    chk("k", 9'h020, k_rx);
    stop_test;
  end
endmodule : test_serial_link_control_regs
`default_nettype wire
